// file: rtl/atd_top.sv
// Purpose: Arming, safing and terminate decision of the termination unit.
// Assumes: Pins are asynchronous; Wishbone and dump port run on clk_i.
// Notes: terminate_o is an AND of flops so it drops with either latch.
`timescale 1ns/1ps

module atd_top #(
	parameter int unsigned TICK_CYC = atd_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [8:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Arm and safe command pins
	input wire logic logic_arm_cmd_i,
	input wire logic logic_safe_cmd_i,
	input wire logic master_arm_cmd_i,
	input wire logic master_safe_cmd_i,
	input wire logic pwr_ok_i,
	// Tracking source pins
	input wire logic [1:0] src_frame_i,
	input wire logic [1:0] src_adequate_i,
	input wire logic [1:0] src_violate_i,
	input wire logic [1:0] src_offcourse_i,
	// Redundant unit heartbeat toggle
	input wire logic peer_hb_i,
	// Image readback stream
	input wire logic dump_ready_i,
	output logic dump_valid_o,
	output logic [31:0] dump_data_o,
	// Termination and monitors
	output logic terminate_o,
	output logic launch_commit_o,
	output logic heartbeat_o,
	output logic green_start_o,
	output logic [1:0] src_adequate_o
);

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [5:0] cmd_s;
	logic [7:0] src_s;

	atd_sync2 #(.WIDTH(6)) u_sync_cmd (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({peer_hb_i, pwr_ok_i, master_safe_cmd_i, master_arm_cmd_i,
			logic_safe_cmd_i, logic_arm_cmd_i}),
		.q_o(cmd_s)
	);

	atd_sync2 #(.WIDTH(8)) u_sync_src (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({src_offcourse_i, src_violate_i, src_adequate_i, src_frame_i}),
		.q_o(src_s)
	);

	// ----------------------------------------
	// Millisecond and sample ticks
	// ----------------------------------------
	logic [17:0] tick_cnt_r;
	logic [6:0] samp_cnt_r;
	wire tick = (tick_cnt_r == 18'(TICK_CYC - 1));
	wire samp = tick && (samp_cnt_r == 7'(atd_pkg::HB_SAMPLE_MS - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_r <= 18'h0_0000;
			samp_cnt_r <= 7'h00;
		end else begin
			tick_cnt_r <= tick ? 18'h0_0000 : tick_cnt_r + 18'h0_0001;
			if (samp) begin
				samp_cnt_r <= 7'h00;
			end else if (tick) begin
				samp_cnt_r <= samp_cnt_r + 7'h01;
			end
		end
	end

	// ----------------------------------------
	// Arm latches and power loss
	// ----------------------------------------
	// Safe commands and power loss beat a simultaneous arm command.
	logic logic_latch_r;
	logic master_latch_r;
	logic [10:0] pwr_ms_r;
	wire pwr_ok_s = cmd_s[4];
	wire pwr_expire = !pwr_ok_s && tick && (pwr_ms_r == 11'(atd_pkg::POWER_OFF_MS));
	wire logic_nxt = (logic_latch_r || cmd_s[0]) && !cmd_s[1] && !pwr_expire;
	wire master_nxt = (master_latch_r || cmd_s[2]) && !cmd_s[3] && !pwr_expire;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			logic_latch_r <= 1'b0;
			master_latch_r <= 1'b0;
			pwr_ms_r <= 11'h000;
		end else begin
			logic_latch_r <= logic_nxt;
			master_latch_r <= master_nxt;
			if (pwr_ok_s) begin
				pwr_ms_r <= 11'h000;
			end else if (tick && !pwr_expire) begin
				pwr_ms_r <= pwr_ms_r + 11'h001;
			end
		end
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic ack_r;
	logic [31:0] rdat_r;
	logic [2:0] ctrl_r;
	logic [15:0] green_cfg_r;
	logic [7:0] hb_thr_r;
	logic [31:0] img_mem [atd_pkg::IMG_DEPTH];
	logic [31:0] status;
	logic [31:0] rd_mux;

	wire req = wb_cyc_i && wb_stb_i;
	wire wr_go = req && wb_we_i && ack_r;
	wire hit_img = wb_adr_i[8];
	wire [5:0] img_idx = wb_adr_i[7:2];
	wire wr_ctrl = wr_go && (wb_adr_i == atd_pkg::ADR_CTRL) && wb_sel_i[0];
	wire wr_green = wr_go && (wb_adr_i == atd_pkg::ADR_GREEN);
	wire wr_kick = wr_go && (wb_adr_i == atd_pkg::ADR_HB_KICK);
	wire wr_thr = wr_go && (wb_adr_i == atd_pkg::ADR_HB_THR) && wb_sel_i[0];
	wire wr_img = wr_go && hit_img;
	wire dump_go = wr_ctrl && wb_dat_i[atd_pkg::CTRL_DUMP_BIT];

	assign rd_mux = hit_img ? img_mem[img_idx] :
		(wb_adr_i == atd_pkg::ADR_CTRL) ? {29'h0, ctrl_r} :
		(wb_adr_i == atd_pkg::ADR_STATUS) ? status :
		(wb_adr_i == atd_pkg::ADR_GREEN) ? {16'h0000, green_cfg_r} :
		(wb_adr_i == atd_pkg::ADR_HB_THR) ? {24'h00_0000, hb_thr_r} : 32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
			ctrl_r <= atd_pkg::CTRL_RST;
			green_cfg_r <= atd_pkg::GREEN_RST;
			hb_thr_r <= atd_pkg::HB_THR_RST;
		end else begin
			ack_r <= req && !ack_r;
			if (req && !ack_r) begin
				rdat_r <= rd_mux;
			end
			if (wr_ctrl) begin
				ctrl_r <= wb_dat_i[2:0] & 3'h5;
			end
			if (wr_green && wb_sel_i[0]) begin
				green_cfg_r[7:0] <= wb_dat_i[7:0];
			end
			if (wr_green && wb_sel_i[1]) begin
				green_cfg_r[15:8] <= wb_dat_i[15:8];
			end
			if (wr_thr) begin
				hb_thr_r <= wb_dat_i[7:0];
			end
		end
	end

	// The image array has no reset so that it maps onto block memory.
	always_ff @(posedge clk_i) begin
		for (int b = 0; b < 4; b++) begin
			if (wr_img && wb_sel_i[b]) begin
				img_mem[img_idx][8*b +: 8] <= wb_dat_i[8*b +: 8];
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// ----------------------------------------
	// Image readback
	// ----------------------------------------
	atd_pkg::atd_dump_e dump_st_r;
	logic [5:0] dump_ptr_r;
	logic [31:0] dump_data_r;
	wire dump_adv = (dump_st_r == atd_pkg::DUMP_SEND) && dump_ready_i;
	wire dump_last = dump_ptr_r == 6'(atd_pkg::IMG_DEPTH - 1);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dump_st_r <= atd_pkg::DUMP_IDLE;
			dump_ptr_r <= 6'h00;
			dump_data_r <= 32'h0000_0000;
		end else begin
			case (dump_st_r)
				atd_pkg::DUMP_IDLE: begin
					if (dump_go) begin
						dump_st_r <= atd_pkg::DUMP_SEND;
						dump_ptr_r <= 6'h00;
						dump_data_r <= img_mem[0];
					end
				end
				atd_pkg::DUMP_SEND: begin
					if (dump_adv && dump_last) begin
						dump_st_r <= atd_pkg::DUMP_IDLE;
					end else if (dump_adv) begin
						dump_ptr_r <= dump_ptr_r + 6'h01;
						dump_data_r <= img_mem[dump_ptr_r + 6'h01];
					end
				end
				default: begin
					dump_st_r <= atd_pkg::DUMP_IDLE;
				end
			endcase
		end
	end

	assign dump_valid_o = dump_st_r == atd_pkg::DUMP_SEND;
	assign dump_data_o = dump_data_r;

	// ----------------------------------------
	// Tracking sources
	// ----------------------------------------
	logic [1:0] has;
	logic [1:0] adq;
	logic [1:0] viol;
	wire run = logic_latch_r;

	for (genvar i = 0; i < atd_pkg::NSRC; i++) begin : g_src
		atd_src_judge u_judge (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.run_i(run),
			.tick_i(tick),
			.frame_i(src_s[i]),
			.adequate_i(src_s[2 + i]),
			.violate_i(src_s[4 + i]),
			.offcourse_i(src_s[6 + i]),
			.has_data_o(has[i]),
			.adequate_o(adq[i]),
			.violate_o(viol[i])
		);
	end

	wire [1:0] n_adq = {1'b0, adq[0]} + {1'b0, adq[1]};
	wire any_viol = |viol;
	wire nodata_inadq = (!has[0] && has[1] && !adq[1]) ||
		(!has[1] && has[0] && !adq[0]);

	// ----------------------------------------
	// Green time after loss of adequate sources
	// ----------------------------------------
	logic green_run_r;
	logic [15:0] green_ms_r;
	wire green_exp = green_run_r && (green_ms_r >= green_cfg_r);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			green_run_r <= 1'b0;
			green_ms_r <= 16'h0000;
		end else begin
			green_run_r <= run && (n_adq == 2'd0);
			if (!green_run_r) begin
				green_ms_r <= 16'h0000;
			end else if (tick && !green_exp) begin
				green_ms_r <= green_ms_r + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Heartbeat monitor, local then peer
	// ----------------------------------------
	logic peer_d_r;
	logic hb_out_r;
	logic [1:0] hb_fail;
	wire [1:0] hb_ev = {cmd_s[5] ^ peer_d_r, wr_kick};

	for (genvar h = 0; h < 2; h++) begin : g_hb
		logic seen_r;
		logic [7:0] miss_r;
		// Duration in ms is checked too, so a short threshold cannot undercut green time.
		assign hb_fail[h] = (miss_r >= hb_thr_r) &&
			(16'(miss_r) * 16'(atd_pkg::HB_SAMPLE_MS) >= green_cfg_r);
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				seen_r <= 1'b0;
				miss_r <= 8'h00;
			end else begin
				seen_r <= hb_ev[h] || (seen_r && !samp);
				if (!run || (samp && (seen_r || hb_ev[h]))) begin
					miss_r <= 8'h00;
				end else if (samp && (miss_r != 8'hff)) begin
					miss_r <= miss_r + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			peer_d_r <= 1'b0;
			hb_out_r <= 1'b0;
		end else begin
			peer_d_r <= cmd_s[5];
			if (samp && run && !hb_fail[0]) begin
				hb_out_r <= !hb_out_r;
			end
		end
	end

	wire hb_both = hb_fail[0] && hb_fail[1];

	// ----------------------------------------
	// Terminate decision and output gate
	// ----------------------------------------
	// Divergence or nominal flight raises no cause, so they never terminate.
	logic term_req_r;
	logic commit_r;
	wire cause = any_viol || nodata_inadq || green_exp || hb_both;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			term_req_r <= 1'b0;
			commit_r <= 1'b0;
		end else begin
			term_req_r <= run && (term_req_r || cause);
			commit_r <= run && (n_adq == 2'd2) && ctrl_r[atd_pkg::CTRL_INDEP_BIT];
		end
	end

	assign terminate_o = term_req_r && logic_latch_r && master_latch_r;
	assign launch_commit_o = commit_r;
	assign heartbeat_o = hb_out_r;
	assign green_start_o = green_run_r;
	assign src_adequate_o = adq;

	assign status = {16'h0000, dump_valid_o, term_req_r, hb_fail[1], hb_fail[0],
		green_run_r, n_adq, adq, has, ctrl_r[atd_pkg::CTRL_BITOK_BIT],
		hb_out_r, terminate_o, master_latch_r, logic_latch_r};

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence dump_req_s;
		(dump_st_r == atd_pkg::DUMP_IDLE) && dump_go;
	endsequence

	sequence dump_run_s;
		dump_valid_o && (dump_ptr_r == 6'h00) ##1 dump_valid_o;
	endsequence

	term_gate_a: assert property (terminate_o |-> !$past(cmd_s[1]) && !$past(cmd_s[3]))
		else $error("terminate held through a safe command");
	logic_run_a: assert property (!logic_latch_r |=> !term_req_r && !commit_r)
		else $error("decision active without logic arm");
	master_fire_a: assert property (term_req_r && logic_latch_r && !master_latch_r
		|-> !terminate_o)
		else $error("fired without master arm");
	pwr_safe_a: assert property (pwr_expire |=> !logic_latch_r && !master_latch_r)
		else $error("latches kept after supply loss");
	arm_hold_a: assert property (logic_latch_r && !cmd_s[1] && !pwr_expire
		|=> logic_latch_r)
		else $error("logic arm latch dropped without safe");
	viol_term_a: assert property (run && any_viol |=> term_req_r)
		else $error("violation did not terminate");
	nodata_term_a: assert property (run && nodata_inadq |=> term_req_r)
		else $error("silent plus inadequate did not terminate");
	commit_two_a: assert property (launch_commit_o |-> $past(n_adq) == 2'd2)
		else $error("commit without two adequate sources");
	no_cause_a: assert property ($rose(term_req_r) |-> $past(cause))
		else $error("terminate without a cause");
	green_term_a: assert property (run && green_exp |=> term_req_r)
		else $error("green time ran out without terminate");
	hb_both_a: assert property (run && hb_both |=> term_req_r)
		else $error("dual heartbeat loss did not terminate");
	dump_start_a: assert property (dump_req_s |=> dump_run_s)
		else $error("image readback did not start");

endmodule

// file: rtl/atd_pkg.sv
// Purpose: Shared constants for the autonomous termination decider.
// Assumes: 200 MHz clk_i, classic Wishbone with 32-bit data.
// Notes: All offsets are byte addresses of aligned words.
//
// Overview of operation
// - Terminate only while both arm latches set.
// - Logic arm enables processing, never firing alone.
// - Master arm latch gates the firing path.
// - Supply lost over one second clears latches.
// - Arm commands latch until safed.
// - Status word and pins report monitor data.
// - Stream loaded image out; ground compares it.
// - Two tracking sources feed the decision.
// - Each source has its own adequacy flag.
// - Launch commit needs two adequate independent sources.
// - All adequate sources lost: terminate at green time.
// - All valid sources violating: terminate.
// - One nominal, other violating: terminate.
// - No data plus inadequate other: terminate.
// - No data plus adequate other: keep running.
// - Divergence without violation does not terminate.
// - Any adequate violating source terminates.
// - Nominal trajectory never terminates.
// - Off course, mission impossible: terminate.
// - Both processors dead or unlinked: terminate.
// - Heartbeats sampled ten times a second at least.
// - Missed-sample threshold never shorter than green time.

package atd_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
	localparam int unsigned POWER_OFF_MS = 1000;
	localparam int unsigned HB_MIN_RATE_HZ = 10;
	// Rounding down keeps the sample rate at or above the minimum.
	localparam int unsigned HB_SAMPLE_MS = 1000 / HB_MIN_RATE_HZ;
	localparam int unsigned DATA_TMO_MS = 20;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int unsigned NSRC = 2;
	localparam int unsigned IMG_DEPTH = 64;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [8:0] ADR_CTRL = 9'h000;
	localparam logic [8:0] ADR_STATUS = 9'h004;
	localparam logic [8:0] ADR_GREEN = 9'h008;
	localparam logic [8:0] ADR_HB_KICK = 9'h00c;
	localparam logic [8:0] ADR_HB_THR = 9'h010;
	localparam logic [8:0] ADR_IMG_BASE = 9'h100;
	localparam int unsigned CTRL_INDEP_BIT = 0;
	localparam int unsigned CTRL_DUMP_BIT = 1;
	localparam int unsigned CTRL_BITOK_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [15:0] GREEN_RST = 16'h0bb8;
	localparam logic [7:0] HB_THR_RST = 8'h1e;
	localparam int unsigned ST_LOGIC = 0;
	localparam int unsigned ST_MASTER = 1;
	localparam int unsigned ST_FIRE = 2;
	localparam int unsigned ST_HB = 3;
	localparam int unsigned ST_BITOK = 4;
	localparam int unsigned ST_DATA = 5;
	localparam int unsigned ST_ADEQ = 7;
	localparam int unsigned ST_NSRC = 9;
	localparam int unsigned ST_GREEN = 11;
	localparam int unsigned ST_LFAIL = 12;
	localparam int unsigned ST_PFAIL = 13;
	localparam int unsigned ST_TREQ = 14;
	localparam int unsigned ST_DUMP = 15;

	// ----------------------------------------
	// Image readback states
	// ----------------------------------------
	typedef enum logic [1:0] {
		DUMP_IDLE = 2'b01,
		DUMP_SEND = 2'b10
	} atd_dump_e;

endpackage

// file: rtl/atd_sync2.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs are slow levels or toggles.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/1ps

module atd_sync2 #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Levels
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;

endmodule

// file: rtl/atd_src_judge.sv
// Purpose: Judges one tracking source for data, adequacy and violation.
// Assumes: frame_i toggles once per new frame; all inputs synchronised.
// Notes: A source counts as silent until its first frame arrives.
`timescale 1ns/1ps

module atd_src_judge (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic run_i,
	input wire logic tick_i,
	// Source levels
	input wire logic frame_i,
	input wire logic adequate_i,
	input wire logic violate_i,
	input wire logic offcourse_i,
	// Judgement
	output logic has_data_o,
	output logic adequate_o,
	output logic violate_o
);

	localparam logic [7:0] TMO = 8'(atd_pkg::DATA_TMO_MS);

	logic frame_d_r;
	logic [7:0] age_r;
	logic [7:0] age_nxt;
	logic has_r;
	logic adq_r;
	logic viol_r;

	wire new_frame = frame_i ^ frame_d_r;
	wire has_nxt = run_i && (age_nxt < TMO);
	wire adq_nxt = has_nxt && adequate_i;
	wire viol_nxt = adq_nxt && (violate_i || offcourse_i);

	always_comb begin
		age_nxt = age_r;
		if (!run_i) begin
			age_nxt = TMO;
		end else if (new_frame) begin
			age_nxt = 8'h00;
		end else if (tick_i && (age_r < TMO)) begin
			age_nxt = age_r + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_d_r <= 1'b0;
			age_r <= TMO;
			has_r <= 1'b0;
			adq_r <= 1'b0;
			viol_r <= 1'b0;
		end else begin
			frame_d_r <= frame_i;
			age_r <= age_nxt;
			has_r <= has_nxt;
			adq_r <= adq_nxt;
			viol_r <= viol_nxt;
		end
	end

	assign has_data_o = has_r;
	assign adequate_o = adq_r;
	assign violate_o = viol_r;

endmodule

// file: sim/atd_src_model.sv
// Purpose: Tracking sources, redundant unit heartbeat and ground link model.
// Assumes: Frames toggle every 8 cycles while a source is enabled.
// Notes: Ground ready stalls at random so the dump sees back-pressure.
`timescale 1ns/1ps

module atd_src_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control from the bench
	input wire logic [1:0] src_en_i,
	input wire logic peer_en_i,
	// Model outputs
	output logic [1:0] src_frame_o,
	output logic peer_hb_o,
	output logic dump_ready_o
);
	logic [6:0] cnt_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 7'h00;
			src_frame_o <= 2'h0;
			peer_hb_o <= 1'b0;
			dump_ready_o <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 7'h01;
			if (cnt_r[2:0] == 3'h7) begin
				src_frame_o <= src_frame_o ^ src_en_i;
			end
			if (cnt_r == 7'h7f) begin
				peer_hb_o <= peer_hb_o ^ peer_en_i;
			end
			dump_ready_o <= ($urandom_range(0, 3) != 0);
		end
	end
endmodule

// file: sim/atd_tb_top.sv
// Purpose: Self-checking bench for the termination decider.
// Assumes: TICK_CYC of 4, so one ms tick lasts 4 clock cycles.
// Notes: Expected results come from the source levels the bench sets.
`timescale 1ns/1ps

module atd_tb_top;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pwr, peer_en, peer_hb;
	logic dump_valid_o, dump_ready, terminate_o, launch_commit_o, heartbeat_o, green_start_o, hb_q;
	logic [8:0] wb_adr_i;
	logic [3:0] wb_sel_i, cmd;
	logic [31:0] wb_dat_i, wb_dat_o, dump_data_o, rd;
	logic [31:0] img [64];
	logic [1:0] fr, adeq, viol, off, en, src_adequate_o;
	logic [7:0] tbl [8];
	int num_errors, compares, hb_flips, didx, n;

	atd_top #(.TICK_CYC(4)) i_atd_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.logic_arm_cmd_i(cmd[0]), .logic_safe_cmd_i(cmd[1]), .master_arm_cmd_i(cmd[2]),
		.master_safe_cmd_i(cmd[3]), .pwr_ok_i(pwr), .src_frame_i(fr), .src_adequate_i(adeq),
		.src_violate_i(viol), .src_offcourse_i(off), .peer_hb_i(peer_hb),
		.dump_ready_i(dump_ready), .dump_valid_o(dump_valid_o), .dump_data_o(dump_data_o),
		.terminate_o(terminate_o), .launch_commit_o(launch_commit_o),
		.heartbeat_o(heartbeat_o), .green_start_o(green_start_o),
		.src_adequate_o(src_adequate_o));
	atd_src_model i_atd_src_model (.clk_i(clk_i), .rst_i(rst_i), .src_en_i(en),
		.peer_en_i(peer_en), .src_frame_o(fr), .peer_hb_o(peer_hb), .dump_ready_o(dump_ready));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("Errors %0d, compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wb(input logic we, input logic [8:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (k >= 20) begin
			num_errors++;
			end_sim();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic pulse(input int i);
		@(posedge clk_i);
		cmd[i] <= 1'b1;
		repeat (4) @(posedge clk_i);
		cmd[i] <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	function automatic logic exp_term(input logic [1:0] e, ad, v, o);
		logic [1:0] a;
		a = e & ad;
		return (|(a & (v | o))) | (a == 2'b00);
	endfunction
	// Each case safes and re-arms logic, because a terminate request is sticky.
	task automatic run_case(input logic [1:0] e, ad, v, o, input logic m);
		logic [1:0] a;
		a = e & ad;
		@(posedge clk_i);
		en <= e;
		adeq <= ad;
		viol <= v;
		off <= o;
		pulse(1);
		pulse(0);
		wb(1, atd_pkg::ADR_HB_KICK, 32'h0000_0000);
		if (e == 2'b11 && ad == 2'b00) begin
			chk("green_run", {green_start_o, terminate_o}, 2'b10);
		end
		repeat (200) @(posedge clk_i);
		chk("terminate", terminate_o, exp_term(e, ad, v, o) & m);
		chk("adequate", src_adequate_o, a);
		chk("commit", launch_commit_o, a == 2'b11);
		wb(0, atd_pkg::ADR_STATUS, 32'h0000_0000);
		chk("src_count", rd[10:9], {1'b0, a[0]} + {1'b0, a[1]});
		chk("latches", rd[1:0], {m, 1'b1});
		chk("self_test", rd[4], 1'b1);
	endtask

	always @(posedge clk_i) begin
		hb_q <= heartbeat_o;
		if (!rst_i && heartbeat_o !== hb_q) begin
			hb_flips++;
		end
		if (dump_valid_o === 1'b1 && dump_ready === 1'b1) begin
			chk("dump_word", dump_data_o, img[didx[5:0]]);
			didx++;
		end
	end

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_i, pwr, peer_en} = 3'b111;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, cmd} = '0;
		{en, adeq, viol, off} = '0;
		wb_sel_i = 4'hf;
		tbl = '{8'hf0, 8'hfc, 8'hf8, 8'h60, 8'h50, 8'hf1, 8'h00, 8'hd8};
		void'($urandom(93));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, atd_pkg::ADR_CTRL, 32'h0000_0000);
		chk("ctrl_rst", rd, {29'h0, atd_pkg::CTRL_RST});
		wb(0, atd_pkg::ADR_GREEN, 32'h0000_0000);
		chk("green_rst", rd, {16'h0, atd_pkg::GREEN_RST});
		wb(0, atd_pkg::ADR_HB_THR, 32'h0000_0000);
		chk("thr_rst", rd, {24'h0, atd_pkg::HB_THR_RST});
		wb(0, 9'h020, 32'h0000_0000);
		chk("unmapped", rd, 32'h0000_0000);
		chk("term_rst", terminate_o, 1'b0);
		wb(1, atd_pkg::ADR_GREEN, 32'h0000_000a);
		wb(1, atd_pkg::ADR_CTRL, 32'h0000_0005);
		wb(0, atd_pkg::ADR_CTRL, 32'h0000_0000);
		chk("ctrl", rd, 32'h0000_0005);
		run_case(2'b11, 2'b11, 2'b11, 2'b00, 1'b0);
		pulse(2);
		chk("fire_armed", terminate_o, 1'b1);
		pulse(3);
		chk("fire_safed", terminate_o, 1'b0);
		pulse(2);
		for (int i = 0; i < 8; i++) begin
			run_case(tbl[i][7:6], tbl[i][5:4], tbl[i][3:2], tbl[i][1:0], 1'b1);
		end
		// Both sources present but inadequate: green time must start and then expire.
		run_case(2'b11, 2'b00, 2'b11, 2'b00, 1'b1);
		repeat (12) begin
			run_case(2'($urandom), 2'($urandom), 2'($urandom), 2'($urandom), 1'b1);
		end
		chk("hb_toggles", hb_flips > 0, 1'b1);
		// A dropout shorter than the expiry must keep the latches.
		@(posedge clk_i);
		pwr <= 1'b0;
		repeat (2000) @(posedge clk_i);
		wb(0, atd_pkg::ADR_STATUS, 32'h0000_0000);
		chk("short_loss", rd[1:0], 2'b11);
		repeat (2200) @(posedge clk_i);
		pwr <= 1'b1;
		repeat (10) @(posedge clk_i);
		wb(0, atd_pkg::ADR_STATUS, 32'h0000_0000);
		chk("long_loss", rd[1:0], 2'b00);
		for (int i = 0; i < 64; i++) begin
			img[i] = $urandom;
			wb(1, atd_pkg::ADR_IMG_BASE + 9'(4 * i), img[i]);
		end
		didx = 0;
		wb(1, atd_pkg::ADR_CTRL, 32'h0000_0007);
		n = 0;
		while (didx < 64 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		repeat (2) @(posedge clk_i);
		chk("dump_count", didx, 64);
		chk("dump_end", dump_valid_o, 1'b0);
		pulse(2);
		run_case(2'b11, 2'b11, 2'b00, 2'b00, 1'b1);
		wb(1, atd_pkg::ADR_HB_THR, 32'h0000_0002);
		peer_en <= 1'b0;
		n = 0;
		while (terminate_o !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		chk("hb_term", terminate_o, 1'b1);
		chk("hb_delay", n >= 400, 1'b1);
		wb(0, atd_pkg::ADR_STATUS, 32'h0000_0000);
		chk("hb_fail", rd[13:12], 2'b11);
		end_sim();
	end
endmodule
